// >>> frec_pkg.sv
// Purpose: Shared constants for the flash row erase controller
// Assumes: AXI4-Lite register map, 32-bit data, byte offsets
// Notes: Offsets, fields, keys and reset values are named here only once
package frec_pkg;
  // Register byte offsets
  localparam logic [7:0] OFF_ADDR_LOW = 8'h00;
  localparam logic [7:0] OFF_ADDR_HIGH = 8'h04;
  localparam logic [7:0] OFF_CONTROL = 8'h08;
  localparam logic [7:0] OFF_UNLOCK = 8'h0C;
  localparam logic [7:0] OFF_IRQ_STATUS = 8'h10;
  localparam logic [7:0] OFF_IRQ_CLEAR = 8'h14;
  localparam logic [7:0] OFF_IRQ_ENABLE = 8'h18;
  localparam logic [7:0] OFF_PROT_ROWS = 8'h1C;
  // Control register fields
  localparam int CTL_START = 0;
  localparam int CTL_WRITE_ENABLE = 1;
  localparam int CTL_ERASE = 2;
  localparam int CTL_SPACE = 3;
  // Interrupt status fields
  localparam int ST_DONE = 0;
  localparam int ST_REFUSED = 1;
  localparam int ST_W = 2;
  // Address layout: 15-bit word address, 32-word rows
  localparam int ADDR_W = 15;
  localparam int HIGH_W = 7;
  localparam int ROW_LSB = 5;
  localparam int ROW_W = 10;
  localparam int ROW_WORDS = 32;
  localparam int WORD_BITS = 14;
  localparam logic [14:0] PFM_MAX_ADDR = 15'h3FFF;
  localparam logic [14:0] UID_MAX_ADDR = 15'h0003;
  // Unlock keys
  localparam logic [7:0] KEY_FIRST = 8'h55;
  localparam logic [7:0] KEY_SECOND = 8'hAA;
  // Reset values
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [ROW_W-1:0] RST_PROT_ROWS = 10'h000;
  // AXI responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// >>> frec_flash_row_erase.sv
// Purpose: Row erase control for program flash and user ID area
// Assumes: Single clock, synchronous active-low reset, flash macro acks erase
// Function
// - Only a whole single row, chosen by the loaded address, is erased
// - A row is 32 words of 14 bits, smallest erasable unit
// - Starting a write never erases; erase only when explicitly selected
// - Space select: clear picks program flash, set picks user ID area
// - Start works only after 0x55 then 0xAA written to unlock register
// - Any break in the unlock steps cancels the operation
// - Protected address: start bit clears and no erase happens
// - Processor held stalled during erase, released when it ends
// - On completion done flag sets; interrupt only if enabled
// - Erase leaves the program write latches untouched
// - Erase leaves write enable as software set it
// - Program space ends at 0x3FFF; higher addresses select no row
//
// The register offsets and the AXI4-Lite register port were left to the implementer.
`timescale 1ns/1ns
module frec_flash_row_erase (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite write address and data
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Core status
  input wire logic seq_break,
  output logic cpu_stall,
  output logic irq,
  // Flash macro erase port; no write latch signal, so latches are never touched
  output logic erase_req,
  output logic erase_space,
  output logic [frec_pkg::ROW_W-1:0] erase_row,
  input wire logic erase_done
);

  typedef enum logic [1:0] {U_IDLE, U_KEY1, U_ARMED} frec_unlock_t;
  typedef enum logic {E_IDLE, E_RUN} frec_erase_t;

  frec_unlock_t ustate_q;
  frec_erase_t estate_q;
  logic [7:0] awaddr_q, araddr_q;
  logic [31:0] wdata_q;
  logic [3:0] wstrb_q;
  logic aw_held_q, w_held_q, wr_fire;
  logic [7:0] addr_low_q;
  logic [frec_pkg::HIGH_W-1:0] addr_high_q;
  logic start_q, write_enable_q, erase_sel_q, space_q;
  logic [frec_pkg::ST_W-1:0] status_q, status_d, enable_q, st_set, st_clr;
  logic [frec_pkg::ROW_W-1:0] prot_rows_q;
  logic [frec_pkg::ADDR_W-1:0] full_addr;
  logic start_req, go, allowed, ctl_wr, mapped_w;
  logic [31:0] rd_mux;
  logic rd_ok;

  // Offset match, shared by write and read decode
  function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
    hit = (a[7:2] == off[7:2]);
  endfunction

  // Is the word address inside the erasable area of the chosen space
  function automatic logic in_range(input logic sp, input logic [14:0] a);
    in_range = sp ? (a <= frec_pkg::UID_MAX_ADDR) : (a <= frec_pkg::PFM_MAX_ADDR);
  endfunction

  assign wr_fire = aw_held_q && w_held_q && !s_axi_bvalid;
  assign full_addr = {addr_high_q, addr_low_q};
  assign ctl_wr = wr_fire && hit(awaddr_q, frec_pkg::OFF_CONTROL) && wstrb_q[0];
  assign start_req = ctl_wr && wdata_q[frec_pkg::CTL_START];
  // Start only counts when armed and nothing is running
  assign go = start_req && ustate_q == U_ARMED && estate_q == E_IDLE;
  // Protected rows sit below the boundary in program space only
  assign allowed = in_range(space_q, full_addr)
    && (space_q || full_addr[14:5] >= prot_rows_q);
  assign mapped_w = hit(awaddr_q, frec_pkg::OFF_ADDR_LOW)
    || hit(awaddr_q, frec_pkg::OFF_ADDR_HIGH) || hit(awaddr_q, frec_pkg::OFF_CONTROL)
    || hit(awaddr_q, frec_pkg::OFF_UNLOCK) || hit(awaddr_q, frec_pkg::OFF_IRQ_STATUS)
    || hit(awaddr_q, frec_pkg::OFF_IRQ_CLEAR) || hit(awaddr_q, frec_pkg::OFF_IRQ_ENABLE)
    || hit(awaddr_q, frec_pkg::OFF_PROT_ROWS);

  // Write address channel: hold one address until the write is done
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_q <= 1'b0;
      awaddr_q <= frec_pkg::RST_BYTE;
      s_axi_awready <= 1'b1;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_held_q <= 1'b1;
      awaddr_q <= s_axi_awaddr;
      s_axi_awready <= 1'b0;
    end else if (wr_fire) begin
      aw_held_q <= 1'b0;
      s_axi_awready <= 1'b1;
    end
  end

  // Write data channel, taken independently of the address
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_held_q <= 1'b0;
      wdata_q <= 32'h00000000;
      wstrb_q <= 4'h0;
      s_axi_wready <= 1'b1;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_held_q <= 1'b1;
      wdata_q <= s_axi_wdata;
      wstrb_q <= s_axi_wstrb;
      s_axi_wready <= 1'b0;
    end else if (wr_fire) begin
      w_held_q <= 1'b0;
      s_axi_wready <= 1'b1;
    end
  end

  // Write response one cycle after both halves are in
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= frec_pkg::RESP_OKAY;
    end else if (wr_fire) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= mapped_w ? frec_pkg::RESP_OKAY : frec_pkg::RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // Address, enable and protection registers; only byte lane 0 matters
  // except the row boundary, which needs two lanes
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      addr_low_q <= frec_pkg::RST_BYTE;
      addr_high_q <= '0;
      enable_q <= '0;
      prot_rows_q <= frec_pkg::RST_PROT_ROWS;
    end else if (wr_fire) begin
      if (hit(awaddr_q, frec_pkg::OFF_ADDR_LOW) && wstrb_q[0]) begin
        addr_low_q <= wdata_q[7:0];
      end
      if (hit(awaddr_q, frec_pkg::OFF_ADDR_HIGH) && wstrb_q[0]) begin
        addr_high_q <= wdata_q[frec_pkg::HIGH_W-1:0];
      end
      if (hit(awaddr_q, frec_pkg::OFF_IRQ_ENABLE) && wstrb_q[0]) begin
        enable_q <= wdata_q[frec_pkg::ST_W-1:0];
      end
      if (hit(awaddr_q, frec_pkg::OFF_PROT_ROWS)) begin
        if (wstrb_q[0]) prot_rows_q[7:0] <= wdata_q[7:0];
        if (wstrb_q[1]) prot_rows_q[9:8] <= wdata_q[9:8];
      end
    end
  end

  // Control bits; hardware never touches write enable
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      write_enable_q <= 1'b0;
      erase_sel_q <= 1'b0;
      space_q <= 1'b0;
    end else if (ctl_wr) begin
      write_enable_q <= wdata_q[frec_pkg::CTL_WRITE_ENABLE];
      erase_sel_q <= wdata_q[frec_pkg::CTL_ERASE];
      space_q <= wdata_q[frec_pkg::CTL_SPACE];
    end
  end

  // Unlock tracker: any write between steps, or a break, disarms it
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ustate_q <= U_IDLE;
    end else if (seq_break) begin
      ustate_q <= U_IDLE;
    end else if (wr_fire) begin
      if (hit(awaddr_q, frec_pkg::OFF_UNLOCK) && wdata_q[7:0] == frec_pkg::KEY_FIRST) begin
        ustate_q <= U_KEY1;
      end else if (hit(awaddr_q, frec_pkg::OFF_UNLOCK) && ustate_q == U_KEY1
                   && wdata_q[7:0] == frec_pkg::KEY_SECOND) begin
        ustate_q <= U_ARMED;
      end else begin
        ustate_q <= U_IDLE;
      end
    end
  end

  // Erase sequencer; a write start without erase select does nothing here,
  // so programming can never erase by itself
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      estate_q <= E_IDLE;
      start_q <= 1'b0;
      erase_req <= 1'b0;
      cpu_stall <= 1'b0;
      erase_space <= 1'b0;
      erase_row <= '0;
    end else begin
      case (estate_q)
        E_IDLE: begin
          if (go && erase_sel_q && write_enable_q && allowed) begin
            estate_q <= E_RUN;
            start_q <= 1'b1;
            erase_req <= 1'b1;
            cpu_stall <= 1'b1;
            erase_space <= space_q;
            erase_row <= full_addr[14:5];
          end else begin
            start_q <= 1'b0;
          end
        end
        E_RUN: begin
          if (erase_done) begin
            estate_q <= E_IDLE;
            start_q <= 1'b0;
            erase_req <= 1'b0;
            cpu_stall <= 1'b0;
          end
        end
        default: begin
          estate_q <= E_IDLE;
        end
      endcase
    end
  end

  // Sticky status; a new event beats a clear in the same cycle
  always_comb begin
    st_set = '0;
    st_set[frec_pkg::ST_DONE] = estate_q == E_RUN && erase_done;
    st_set[frec_pkg::ST_REFUSED] = go && erase_sel_q && write_enable_q && !allowed;
    st_clr = '0;
    if (wr_fire && hit(awaddr_q, frec_pkg::OFF_IRQ_CLEAR) && wstrb_q[0]) begin
      st_clr = wdata_q[frec_pkg::ST_W-1:0];
    end
    status_d = (status_q & ~st_clr) | st_set;
  end

  // Status and interrupt level
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      status_q <= '0;
      irq <= 1'b0;
    end else begin
      status_q <= status_d;
      irq <= |(status_d & enable_q);
    end
  end

  // Read decode
  always_comb begin
    rd_mux = 32'h00000000;
    rd_ok = 1'b1;
    if (hit(araddr_q, frec_pkg::OFF_ADDR_LOW)) begin
      rd_mux[7:0] = addr_low_q;
    end else if (hit(araddr_q, frec_pkg::OFF_ADDR_HIGH)) begin
      rd_mux[frec_pkg::HIGH_W-1:0] = addr_high_q;
    end else if (hit(araddr_q, frec_pkg::OFF_CONTROL)) begin
      rd_mux[3:0] = {space_q, erase_sel_q, write_enable_q, start_q};
    end else if (hit(araddr_q, frec_pkg::OFF_IRQ_STATUS)) begin
      rd_mux[frec_pkg::ST_W-1:0] = status_q;
    end else if (hit(araddr_q, frec_pkg::OFF_IRQ_ENABLE)) begin
      rd_mux[frec_pkg::ST_W-1:0] = enable_q;
    end else if (hit(araddr_q, frec_pkg::OFF_PROT_ROWS)) begin
      rd_mux[frec_pkg::ROW_W-1:0] = prot_rows_q;
    end else if (!hit(araddr_q, frec_pkg::OFF_UNLOCK)
                 && !hit(araddr_q, frec_pkg::OFF_IRQ_CLEAR)) begin
      rd_ok = 1'b0;
    end
  end

  // Read channel: address taken, data one edge later
  logic ar_held_q;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ar_held_q <= 1'b0;
      araddr_q <= frec_pkg::RST_BYTE;
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= frec_pkg::RESP_OKAY;
    end else begin
      if (s_axi_arvalid && s_axi_arready) begin
        ar_held_q <= 1'b1;
        araddr_q <= s_axi_araddr;
        s_axi_arready <= 1'b0;
      end else if (ar_held_q && !s_axi_rvalid) begin
        ar_held_q <= 1'b0;
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= rd_mux;
        s_axi_rresp <= rd_ok ? frec_pkg::RESP_OKAY : frec_pkg::RESP_SLVERR;
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
        s_axi_arready <= 1'b1;
      end
    end
  end

  // Checks
  sequence s_key_in;
    ustate_q == U_ARMED;
  endsequence
  sequence s_launch;
    !erase_req ##1 erase_req;
  endsequence

  property p_launch_needs_keys;
    @(posedge aclk) disable iff (!aresetn) s_launch |-> $past(ustate_q == U_ARMED, 1);
  endproperty
  a_launch_needs_keys: assert property (p_launch_needs_keys)
    else $error("erase launched without unlock");

  property p_break_disarms;
    @(posedge aclk) disable iff (!aresetn) s_key_in ##0 seq_break |=> ustate_q == U_IDLE;
  endproperty
  a_break_disarms: assert property (p_break_disarms)
    else $error("unlock survived a break");

  property p_refuse;
    @(posedge aclk) disable iff (!aresetn)
      go && erase_sel_q && write_enable_q && !allowed |=> !erase_req && !start_q
      && status_q[frec_pkg::ST_REFUSED];
  endproperty
  a_refuse: assert property (p_refuse)
    else $error("protected erase not refused");

  property p_stall_tracks;
    @(posedge aclk) disable iff (!aresetn) cpu_stall == (estate_q == E_RUN);
  endproperty
  a_stall_tracks: assert property (p_stall_tracks)
    else $error("stall not matching erase");

  property p_done_flag;
    @(posedge aclk) disable iff (!aresetn)
      erase_req && erase_done |=> !cpu_stall && status_q[frec_pkg::ST_DONE];
  endproperty
  a_done_flag: assert property (p_done_flag)
    else $error("done flag missing");

  property p_irq_gate;
    @(posedge aclk) disable iff (!aresetn)
      ##1 irq == |(status_q & $past(enable_q));
  endproperty
  a_irq_gate: assert property (p_irq_gate)
    else $error("irq not gated by enable");

  property p_write_enable_kept;
    @(posedge aclk) disable iff (!aresetn) erase_req && !ctl_wr |=> $stable(write_enable_q);
  endproperty
  a_write_enable_kept: assert property (p_write_enable_kept)
    else $error("write enable changed by erase");

  property p_range;
    @(posedge aclk) disable iff (!aresetn)
      s_launch |-> erase_space ? erase_row == '0 : !erase_row[frec_pkg::ROW_W-1];
  endproperty
  a_range: assert property (p_range)
    else $error("erase outside erasable area");

  property p_row_held;
    @(posedge aclk) disable iff (!aresetn) erase_req && !erase_done |=> $stable(erase_row);
  endproperty
  a_row_held: assert property (p_row_held)
    else $error("row changed mid erase");

endmodule // frec_flash_row_erase

// >>> test_frec_flash_row_erase.sv
// Purpose: Self-checking bench for the flash row erase controller
// Assumes: Bench masters AXI4-Lite and stands in for the flash macro
// Notes: Reads and erase launches are noted in queues and checked by a monitor
`timescale 1ns/1ns
module test_frec_flash_row_erase;
  logic aclk;
  logic aresetn;
  logic [7:0] s_axi_awaddr;
  logic s_axi_awvalid;
  logic s_axi_awready;
  logic [31:0] s_axi_wdata;
  logic [3:0] s_axi_wstrb;
  logic s_axi_wvalid;
  logic s_axi_wready;
  logic [1:0] s_axi_bresp;
  logic s_axi_bvalid;
  logic s_axi_bready;
  logic [7:0] s_axi_araddr;
  logic s_axi_arvalid;
  logic s_axi_arready;
  logic [31:0] s_axi_rdata;
  logic [1:0] s_axi_rresp;
  logic s_axi_rvalid;
  logic s_axi_rready;
  logic seq_break;
  logic cpu_stall;
  logic irq;
  logic erase_req;
  logic erase_space;
  logic [frec_pkg::ROW_W-1:0] erase_row;
  logic erase_done;
  logic [33:0] exp_rd[$];
  logic [10:0] exp_er[$];
  logic req_q;
  logic [2:0] dly;
  logic [15:0] rnd;
  logic [1:0] en;
  logic [14:0] a;
  int err_count;
  int n_compared;

  frec_flash_row_erase uut (
    .aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .seq_break(seq_break),
    .cpu_stall(cpu_stall), .irq(irq), .erase_req(erase_req), .erase_space(erase_space),
    .erase_row(erase_row), .erase_done(erase_done)
  );

  // Clock at 50 MHz
  initial begin
    aclk = 1'b0;
    forever #10 aclk = ~aclk;
  end

  // Random source, fixed seed
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction

  task automatic chk(input logic [33:0] seen, input logic [33:0] exp);
    n_compared++;
    if (seen !== exp) begin
      err_count++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic print_verdict();
    $display("compared %0d, mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  // Write one word; both channels offered together, released as each is taken
  task automatic wr(input logic [7:0] ad, input logic [31:0] d, input logic [1:0] er);
    int n;
    n = 0;
    s_axi_awaddr <= ad;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
      if (s_axi_awready && s_axi_awvalid) s_axi_awvalid <= 1'b0;
      if (s_axi_wready && s_axi_wvalid) s_axi_wvalid <= 1'b0;
    end while (!(s_axi_bvalid && s_axi_bready) && n < 50);
    if (n >= 50) err_count++;
    chk(34'(s_axi_bresp), 34'(er));
  endtask

  // Read one word; the monitor compares the answer with the noted value
  task automatic rd(input logic [7:0] ad, input logic [33:0] e);
    int n;
    n = 0;
    exp_rd.push_back(e);
    s_axi_araddr <= ad;
    s_axi_arvalid <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
      if (s_axi_arready && s_axi_arvalid) s_axi_arvalid <= 1'b0;
    end while (!(s_axi_rvalid && s_axi_rready) && n < 50);
    if (n >= 50) err_count++;
  endtask

  // One cycle of seq_break, raised just after an edge
  task automatic brk_pulse();
    seq_break <= 1'b1;
    @(posedge aclk);
    seq_break <= 1'b0;
  endtask

  // Full erase attempt; st is the expected status (1 done, 2 refused, 0 nothing)
  // brk 1 slips a register write into the unlock, brk 2 raises seq_break there,
  // brk 3 raises it once the unlock is armed
  task automatic ers(input logic sp, input logic [14:0] ea, input logic [1:0] st,
                     input logic [1:0] brk);
    int n;
    n = 0;
    wr(frec_pkg::OFF_ADDR_LOW, 32'(ea[7:0]), frec_pkg::RESP_OKAY);
    wr(frec_pkg::OFF_ADDR_HIGH, 32'(ea[14:8]), frec_pkg::RESP_OKAY);
    wr(frec_pkg::OFF_CONTROL, 32'({sp, 3'b110}), frec_pkg::RESP_OKAY);
    wr(frec_pkg::OFF_UNLOCK, 32'(frec_pkg::KEY_FIRST), frec_pkg::RESP_OKAY);
    if (brk == 2'h1) wr(frec_pkg::OFF_ADDR_LOW, 32'(ea[7:0]), frec_pkg::RESP_OKAY);
    if (brk == 2'h2) brk_pulse();
    wr(frec_pkg::OFF_UNLOCK, 32'(frec_pkg::KEY_SECOND), frec_pkg::RESP_OKAY);
    if (brk == 2'h3) brk_pulse();
    if (st == 2'h1) exp_er.push_back({sp, ea[14:5]});
    wr(frec_pkg::OFF_CONTROL, 32'({sp, 3'b111}), frec_pkg::RESP_OKAY);
    // Launch lands on the same edge that raises the response
    do begin
      @(posedge aclk);
      n++;
    end while ((erase_req || n < 2) && n < 40);
    rd(frec_pkg::OFF_IRQ_STATUS, 34'(st));
    rd(frec_pkg::OFF_CONTROL, 34'({sp, 3'b110}));
    chk(34'(irq), 34'(|(st & en)));
    wr(frec_pkg::OFF_IRQ_CLEAR, 32'h0000_0003, frec_pkg::RESP_OKAY);
    rd(frec_pkg::OFF_IRQ_STATUS, 34'h0_0000_0000);
    // Software guards against stray writes once the erase is over
    wr(frec_pkg::OFF_CONTROL, 32'({sp, 3'b100}), frec_pkg::RESP_OKAY);
    rd(frec_pkg::OFF_CONTROL, 34'({sp, 3'b100}));
  endtask

  // Flash macro stand-in: done pulse after a random wait
  always @(posedge aclk) begin
    erase_done <= 1'b0;
    if (!aresetn) dly <= 3'h1;
    else if (erase_req && !erase_done) begin
      if (dly == 3'h0) begin
        erase_done <= 1'b1;
        dly <= rnd[2:0];
      end else dly <= dly - 3'h1;
    end
  end

  // Monitor: read answers, erase launches and the stall
  always @(posedge aclk) begin
    req_q <= erase_req;
    if (aresetn && s_axi_rvalid && s_axi_rready) begin
      if (exp_rd.size() > 0) chk({s_axi_rresp, s_axi_rdata}, exp_rd.pop_front());
      else chk(34'h0, 34'h1);
    end
    if (erase_req && !req_q) begin
      if (exp_er.size() > 0) chk(34'({erase_space, erase_row}), 34'(exp_er.pop_front()));
      else chk(34'h1, 34'h0);
    end
    if (aresetn) chk(34'(cpu_stall), 34'(erase_req));
  end

  // Watchdog for a hung handshake
  initial begin
    repeat (30000) @(posedge aclk);
    err_count++;
    print_verdict();
  end

  // Main sequence
  initial begin
    err_count = 0;
    n_compared = 0;
    aresetn = 1'b0;
    {s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wvalid, s_axi_araddr} = '0;
    s_axi_arvalid = 1'b0;
    seq_break = 1'b0;
    s_axi_wstrb = 4'hF;
    s_axi_bready = 1'b1;
    s_axi_rready = 1'b1;
    erase_done = 1'b0;
    req_q = 1'b0;
    rnd = 16'hDA9E;
    en = 2'h3;
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    // Reset values and refused places
    rd(frec_pkg::OFF_PROT_ROWS, 34'h0_0000_0000);
    rd(frec_pkg::OFF_IRQ_STATUS, 34'h0_0000_0000);
    rd(8'h40, {frec_pkg::RESP_SLVERR, 32'h0000_0000});
    wr(8'h40, 32'h0000_0001, frec_pkg::RESP_SLVERR);
    wr(frec_pkg::OFF_IRQ_ENABLE, 32'(en), frec_pkg::RESP_OKAY);
    // Random program rows, then the edges of the program space
    for (int i = 0; i < 4; i++) begin
      a = {1'b0, rnd[13:0]};
      rnd = lfsr(rnd);
      ers(1'b0, a, 2'h1, 2'h0);
    end
    ers(1'b0, 15'h3FFF, 2'h1, 2'h0);
    ers(1'b0, 15'h4000, 2'h2, 2'h0);
    // Protected rows below the limit are refused
    wr(frec_pkg::OFF_PROT_ROWS, 32'h0000_0004, frec_pkg::RESP_OKAY);
    ers(1'b0, 15'h0060, 2'h2, 2'h0);
    ers(1'b0, 15'h0080, 2'h1, 2'h0);
    wr(frec_pkg::OFF_PROT_ROWS, 32'h0000_0000, frec_pkg::RESP_OKAY);
    // User ID space and the areas beyond it
    ers(1'b1, 15'h0003, 2'h1, 2'h0);
    ers(1'b1, 15'h0004, 2'h2, 2'h0);
    // Broken unlock sequences
    ers(1'b0, 15'h1234, 2'h0, 2'h1);
    ers(1'b0, 15'h1234, 2'h0, 2'h2);
    ers(1'b0, 15'h1234, 2'h0, 2'h3);
    // Start without erase select never erases; select is cleared before unlocking
    wr(frec_pkg::OFF_CONTROL, 32'h0000_0002, frec_pkg::RESP_OKAY);
    wr(frec_pkg::OFF_UNLOCK, 32'(frec_pkg::KEY_FIRST), frec_pkg::RESP_OKAY);
    wr(frec_pkg::OFF_UNLOCK, 32'(frec_pkg::KEY_SECOND), frec_pkg::RESP_OKAY);
    wr(frec_pkg::OFF_CONTROL, 32'h0000_0003, frec_pkg::RESP_OKAY);
    repeat (4) @(posedge aclk);
    rd(frec_pkg::OFF_IRQ_STATUS, 34'h0_0000_0000);
    // Masked interrupt stays low after a good erase
    en = 2'h0;
    wr(frec_pkg::OFF_IRQ_ENABLE, 32'(en), frec_pkg::RESP_OKAY);
    ers(1'b0, 15'h2345, 2'h1, 2'h0);
    repeat (4) @(posedge aclk);
    chk(34'(exp_er.size() + exp_rd.size()), 34'h0);
    print_verdict();
  end
endmodule // test_frec_flash_row_erase
